// ==== shared/itr_pkg.sv ====
// Constants, cell map and types of the thermometer sequencer and thermal relay
package itr_pkg;
  // Nonvolatile cell addresses
  localparam logic [5:0] CELL_MODE_CFG = 6'h02;
  localparam logic [5:0] CELL_RELAY_HYS = 6'h20;
  localparam logic [5:0] CELL_RELAY_THR = 6'h21;
  localparam logic [5:0] CELL_PULSE_CTRL = 6'h22;
  localparam logic [5:0] CELL_SLAVE_ADDR = 6'h2e;
  localparam int NV_CELLS = 5;
  localparam logic [2:0] NV_LAST = 3'h4;
  // Field positions in output_mode_config
  localparam int CFG_IIR_LSB = 0;
  localparam int CFG_RELAY_SEL = 3;
  localparam int CFG_DUAL = 6;
  localparam int CFG_DIE_SEL = 7;
  localparam int CFG_FIR_LSB = 8;
  localparam int CFG_PWM_EN = 11;
  // Field positions in pulse_control_cell and the slave address cell
  localparam int PCTL_DRIVE_TYPE = 2;
  localparam int ADDR_LSB = 0;
  // Fixed filter lengths for the offset and gain measurements
  localparam logic [2:0] FIR_FIXED_LEN = 3'h7;
  localparam logic [2:0] IIR_FIXED_LEN = 3'h4;
  // Request time on the clock line and system clock rate
  localparam int T_REQ_US = 1000;
  localparam int CLK_MHZ = 100;
  localparam int REQ_CYC = T_REQ_US * CLK_MHZ;
  localparam int REQ_W = 20;
  // Step codes of the measurement loop, also the result cell indices
  localparam logic [3:0] ST_AMB_OFS = 4'h0;
  localparam logic [3:0] ST_DIE = 4'h1;
  localparam logic [3:0] ST_AMB_T = 4'h2;
  localparam logic [3:0] ST_IR_OFS = 4'h3;
  localparam logic [3:0] ST_IR_GAIN = 4'h4;
  localparam logic [3:0] ST_GAIN_K = 4'h5;
  localparam logic [3:0] ST_IR1 = 4'h6;
  localparam logic [3:0] ST_OBJ1 = 4'h7;
  localparam logic [3:0] ST_IR2 = 4'h8;
  localparam logic [3:0] ST_OBJ2 = 4'h9;
  localparam logic [3:0] ST_PWM = 4'ha;
  localparam int RES_CELLS = 11;
  // Sequencer states, Gray along load, issue, wait
  typedef enum logic [1:0] {
    ITR_LOAD = 2'b00,
    ITR_ISSUE = 2'b01,
    ITR_WAIT = 2'b11
  } itr_state_e;
endpackage

// ==== shared/itr_relay_if.sv ====
// Signals between the sequencer and the relay comparator
`timescale 1ns/1ps
interface itr_relay_if;
  logic [15:0] obj1;
  logic [15:0] thr;
  logic [15:0] hys;
  logic upd;
  logic en;
  logic relay;
  modport seq (output obj1, output thr, output hys, output upd, output en, input relay);
  modport cmp (input obj1, input thr, input hys, input upd, input en, output relay);
endinterface

// ==== hw/itr_relay_cmp.sv ====
// Thermal relay comparator with threshold and hysteresis
`timescale 1ns/1ps
module itr_relay_cmp
  import itr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  itr_relay_if.cmp rif
);
  logic relay_ff;
  logic nxt_relay;
  wire [16:0] obj_cent = {rif.obj1, 1'b0}; // 0.02 K steps to hundredths of a kelvin
  wire [16:0] upper = {1'b0, rif.thr} + {1'b0, rif.hys};
  wire [16:0] lower = (rif.thr >= rif.hys) ? {1'b0, rif.thr - rif.hys} : 17'h00000;
  wire go_high = obj_cent >= upper;
  wire go_low = obj_cent <= lower;

  // Switch at the outer levels, forced low while not enabled, otherwise hold
  always_comb begin
    nxt_relay = relay_ff;
    if (!rif.en) begin
      nxt_relay = 1'b0;
    end else if (rif.upd && go_high) begin
      nxt_relay = 1'b1;
    end else if (rif.upd && go_low) begin
      nxt_relay = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      relay_ff <= 1'b0;
    end else if (i_ce) begin
      relay_ff <= nxt_relay;
    end
  end

  assign rif.relay = relay_ff;

  a_relay_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && rif.en && rif.upd && go_high) |=> rif.relay)
    else $error("relay not high above upper level");
  a_relay_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && rif.en && rif.upd && go_low && !go_high) |=> !rif.relay)
    else $error("relay not low below lower level");
  a_relay_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && rif.en && !go_high && !go_low) |=> $stable(rif.relay))
    else $error("relay changed inside hysteresis band");
endmodule

// ==== hw/itr_top.sv ====
// Measurement sequencer, output mode control and thermal relay pin driver
`timescale 1ns/1ps
// How it works
// - Calibration cells are read from nonvolatile storage before any step runs.
// - Init takes sensor count and die element choice from the mode cell.
// - After init the step loop repeats forever with no trigger.
// - Ambient offset uses fixed FIR then fixed IIR, stored as a result.
// - Die step uses programmable FIR and IIR, then ambient temperature is stored.
// - Object work is shared part, first sensor, second sensor skipped if single.
// - Shared part stores IR offset, IR gain, then the gain factor, all fixed.
// - Each sensor: programmable FIR and IIR filtered value, then object result.
// - Each pass ends with a 10-bit rescaled word loaded to the pulse output.
// - All programmable FIR steps share one length, all IIR steps another.
// - Relay compares first object result and gives a logic level only.
// - Relay acts only with relay select and pulse output enable both set.
// - Drive type bit picks push-pull or open-drain on the pin.
// - Threshold comes from cell 021h, hysteresis from cell 020h.
// - Pin high at or above upper level, low at or below lower level.
// - Relay mode keeps measuring and takes the same bus entry request.
// - After leaving for the bus, relay returns only after a reset or sleep exit.
// - The seven-bit bus address comes from a nonvolatile cell.
// - With pulse output as default, frames run after reset with no command.
// - Pulse output starts when enabled and clock high, bus entry stays possible.
// - Clock low beyond the request time disables pulse output, data ignored.
// - Once disabled, pulse output returns only after power cycle or sleep exit.
// - With pulse output disabled the pin serves the bus once the cell load ends.
module itr_top
  import itr_pkg::*;
#(
  parameter int REQ_CYCLES = REQ_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sleep_exit,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_sda_rx,
  output logic o_bus_mode,
  output logic [5:0] o_nv_addr,
  output logic o_nv_rd,
  input wire logic [15:0] i_nv_data,
  input wire logic i_nv_valid,
  output logic o_step_go,
  output logic [3:0] o_step_id,
  output logic [2:0] o_fir_len,
  output logic [2:0] o_iir_len,
  output logic o_die_sel,
  input wire logic i_step_done,
  input wire logic [15:0] i_step_value,
  output logic [9:0] o_pwm_word,
  output logic o_pwm_load,
  input wire logic i_pwm_level,
  output logic [6:0] o_slave_addr,
  input wire logic [3:0] i_res_idx,
  output logic [15:0] o_res_data
);
  localparam logic [REQ_W-1:0] REQ_LIM = REQ_W'(REQ_CYCLES);

  itr_state_e state_ff, nxt_state;
  logic [2:0] nv_idx_ff;
  logic nv_pend_ff;
  logic [15:0] cfg_ff, hys_ff, thr_ff, pctl_ff, addr_ff;
  logic [3:0] step_ff;
  logic [15:0] res_ff [RES_CELLS];
  logic scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff;
  logic [REQ_W-1:0] low_cnt_ff;
  logic pwm_on_ff;
  logic relay_upd_ff;
  itr_relay_if rif ();

  wire nv_take = (state_ff == ITR_LOAD) && nv_pend_ff && i_nv_valid;
  wire load_done = nv_take && (nv_idx_ff == NV_LAST);
  // Slot of the next read: first cell on re-init, one on after each take
  wire [2:0] nv_slot = (i_sleep_exit || state_ff != ITR_LOAD) ? 3'h0 :
                       nv_take ? nv_idx_ff + 3'h1 : nv_idx_ff;
  // Cell address for each load slot, registered so it stands with the request
  wire [5:0] nv_addr_w = (nv_slot == 3'h0) ? CELL_MODE_CFG :
                         (nv_slot == 3'h1) ? CELL_RELAY_HYS :
                         (nv_slot == 3'h2) ? CELL_RELAY_THR :
                         (nv_slot == 3'h3) ? CELL_PULSE_CTRL : CELL_SLAVE_ADDR;
  wire dual_w = cfg_ff[CFG_DUAL];
  wire prog_step = (step_ff == ST_DIE) || (step_ff == ST_IR1) || (step_ff == ST_IR2);
  wire step_take = (state_ff == ITR_WAIT) && i_step_done;
  wire last_step = step_ff == ST_PWM;
  // Skip the second sensor when only one is configured
  wire [3:0] step_inc = step_ff + 4'h1;
  wire [3:0] nxt_step_w = last_step ? ST_AMB_OFS :
                          (!dual_w && step_ff == ST_OBJ1) ? ST_PWM : step_inc;
  wire scl_low = !scl_s_ff;
  wire req_hit = pwm_on_ff && scl_low && (low_cnt_ff == REQ_LIM);
  wire relay_act = cfg_ff[CFG_RELAY_SEL] && pwm_on_ff;
  wire pin_level = relay_act ? rif.relay : i_pwm_level;
  wire drive_pp = pctl_ff[PCTL_DRIVE_TYPE];

  // Sequencer state transitions
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ITR_LOAD: if (load_done) nxt_state = ITR_ISSUE;
      ITR_ISSUE: nxt_state = ITR_WAIT;
      ITR_WAIT: if (i_step_done) nxt_state = ITR_ISSUE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ITR_LOAD;
    end else if (i_ce) begin
      state_ff <= i_sleep_exit ? ITR_LOAD : nxt_state;
    end
  end

  // Nonvolatile load: one read outstanding at a time
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      nv_idx_ff <= 3'h0;
      nv_pend_ff <= 1'b0;
      o_nv_addr <= CELL_MODE_CFG;
    end else if (i_ce) begin
      o_nv_addr <= nv_addr_w;
      if (i_sleep_exit || state_ff != ITR_LOAD) begin
        nv_idx_ff <= 3'h0;
        nv_pend_ff <= 1'b0;
      end else if (nv_take) begin
        nv_idx_ff <= nv_idx_ff + 3'h1;
        nv_pend_ff <= 1'b0;
      end else if (!nv_pend_ff) begin
        nv_pend_ff <= 1'b1;
      end
    end
  end

  // Read request stands from the pending flop until the cell answers
  assign o_nv_rd = nv_pend_ff;

  // Calibration and configuration cells
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cfg_ff <= 16'h0000;
      hys_ff <= 16'h0000;
      thr_ff <= 16'h0000;
      pctl_ff <= 16'h0000;
      addr_ff <= 16'h0000;
    end else if (i_ce && nv_take) begin
      if (nv_idx_ff == 3'h0) cfg_ff <= i_nv_data;
      if (nv_idx_ff == 3'h1) hys_ff <= i_nv_data;
      if (nv_idx_ff == 3'h2) thr_ff <= i_nv_data;
      if (nv_idx_ff == 3'h3) pctl_ff <= i_nv_data;
      if (nv_idx_ff == 3'h4) addr_ff <= i_nv_data;
    end
  end

  // Step pointer walks the fixed order of the loop
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      step_ff <= ST_AMB_OFS;
    end else if (i_ce) begin
      if (state_ff == ITR_LOAD || i_sleep_exit) step_ff <= ST_AMB_OFS;
      else if (step_take) step_ff <= nxt_step_w;
    end
  end

  // Result cells, one per step
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < RES_CELLS; i++) res_ff[i] <= 16'h0000;
    end else if (i_ce && step_take) begin
      res_ff[step_ff] <= i_step_value;
    end
  end

  // Step request and filter lengths toward the DSP core
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_step_go <= 1'b0;
      o_step_id <= ST_AMB_OFS;
      o_fir_len <= 3'h0;
      o_iir_len <= 3'h0;
      o_die_sel <= 1'b0;
    end else if (i_ce) begin
      o_step_go <= (state_ff == ITR_ISSUE) && !i_sleep_exit;
      o_step_id <= step_ff;
      o_fir_len <= prog_step ? cfg_ff[CFG_FIR_LSB +: 3] : FIR_FIXED_LEN;
      o_iir_len <= prog_step ? cfg_ff[CFG_IIR_LSB +: 3] : IIR_FIXED_LEN;
      o_die_sel <= cfg_ff[CFG_DIE_SEL];
    end
  end

  // Pulse word load at the end of each pass
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pwm_word <= 10'h000;
      o_pwm_load <= 1'b0;
      relay_upd_ff <= 1'b0;
    end else if (i_ce) begin
      o_pwm_load <= step_take && last_step;
      if (step_take && last_step) o_pwm_word <= i_step_value[9:0];
      relay_upd_ff <= step_take && (step_ff == ST_OBJ1);
    end
  end

  // Two-stage synchronisers for the pins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else if (i_ce) begin
      scl_m_ff <= i_scl;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= i_sda_in;
      sda_s_ff <= sda_m_ff;
    end
  end

  // Request detector: count clock-low time while pulse output runs
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_ff <= '0;
    end else if (i_ce) begin
      if (!pwm_on_ff || !scl_low) low_cnt_ff <= '0;
      else if (low_cnt_ff != REQ_LIM) low_cnt_ff <= low_cnt_ff + 1'b1;
    end
  end

  // Output mode: chosen at end of load, dropped for good by a request
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pwm_on_ff <= 1'b0;
    end else if (i_ce) begin
      if (i_sleep_exit) pwm_on_ff <= 1'b0;
      else if (load_done) pwm_on_ff <= cfg_ff[CFG_PWM_EN] && !scl_low;
      else if (req_hit) pwm_on_ff <= 1'b0;
    end
  end

  assign rif.obj1 = res_ff[ST_OBJ1];
  assign rif.thr = thr_ff;
  assign rif.hys = hys_ff;
  assign rif.upd = relay_upd_ff;
  assign rif.en = relay_act;

  itr_relay_cmp u_cmp (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .rif(rif)
  );

  // Pin driver, bus side outputs and result read port
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sda_out <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_sda_rx <= 1'b1;
      o_bus_mode <= 1'b0;
      o_slave_addr <= 7'h00;
      o_res_data <= 16'h0000;
    end else if (i_ce) begin
      o_sda_out <= pwm_on_ff && drive_pp && pin_level;
      o_sda_oe_n <= !pwm_on_ff || (!drive_pp && pin_level);
      o_sda_rx <= pwm_on_ff ? 1'b1 : sda_s_ff;
      o_bus_mode <= !pwm_on_ff && (state_ff != ITR_LOAD);
      o_slave_addr <= addr_ff[ADDR_LSB +: 7];
      o_res_data <= (i_res_idx < 4'(RES_CELLS)) ? res_ff[i_res_idx] : 16'h0000;
    end
  end

  a_load_first: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_ff == ITR_LOAD) |=> !o_step_go)
    else $error("step issued during calibration load");
  a_single_skip: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && !i_sleep_exit && step_take && !dual_w && step_ff == ST_OBJ1) |=> step_ff == ST_PWM)
    else $error("second sensor not skipped");
  a_loop_wraps: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && !i_sleep_exit && step_take && last_step) |=> step_ff == ST_AMB_OFS ##1 o_step_go)
    else $error("loop did not restart");
  a_pwm_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && step_take && last_step) |=> o_pwm_load && o_pwm_word == $past(i_step_value[9:0]))
    else $error("pulse word not loaded");
  a_req_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && req_hit && !i_sleep_exit && !load_done) |=> !pwm_on_ff ##1 !o_sda_out && o_sda_oe_n)
    else $error("request did not release pin");
  a_stay_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!pwm_on_ff && !load_done) |=> !pwm_on_ff)
    else $error("pulse output came back without reset");
  a_prog_len: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && prog_step) |=> o_fir_len == cfg_ff[CFG_FIR_LSB +: 3])
    else $error("programmable length not shared");
  a_relay_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!cfg_ff[CFG_RELAY_SEL] || !pwm_on_ff) |=> !rif.relay)
    else $error("relay active while not enabled");
  c_full_pass: cover property (@(posedge i_clk_sys) o_pwm_load);
  c_request: cover property (@(posedge i_clk_sys) req_hit);
  c_relay_on: cover property (@(posedge i_clk_sys) rif.relay && relay_act);
  c_dual_pass: cover property (@(posedge i_clk_sys) step_take && step_ff == ST_OBJ2);
endmodule

// ==== sim/itr_far_model.sv ====
// Calibration cells and DSP step engine facing the sequencer
`timescale 1ns/1ps
module itr_far_model
  import itr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [5:0] i_nv_addr,
  input wire logic i_nv_rd,
  input wire logic i_step_go,
  input wire logic [3:0] i_step_id,
  input wire logic [15:0] i_cfg,
  input wire logic [15:0] i_pctl,
  input wire logic [15:0] i_obj1,
  input wire logic i_slow,
  output logic [15:0] o_nv_data,
  output logic o_nv_valid,
  output logic o_step_done,
  output logic [15:0] o_step_value
);
  logic [3:0] id_ff;
  logic [3:0] cnt_ff;
  logic busy_ff;
  // Cell contents by address, unmapped cells read a marker pattern
  always_comb begin
    case (i_nv_addr)
      CELL_MODE_CFG: o_nv_data = i_cfg;
      CELL_RELAY_HYS: o_nv_data = 16'h0064;
      CELL_RELAY_THR: o_nv_data = 16'h6ca7;
      CELL_PULSE_CTRL: o_nv_data = i_pctl;
      CELL_SLAVE_ADDR: o_nv_data = 16'h005a;
      default: o_nv_data = 16'hdead;
    endcase
  end
  // One answer per pending read, never two in a row
  always_ff @(posedge i_clk_sys) begin
    o_nv_valid <= i_nv_rd && !o_nv_valid;
  end
  // Step engine answers promptly or after a stall
  always_ff @(posedge i_clk_sys) begin
    o_step_done <= 1'b0;
    if (i_step_go) begin
      busy_ff <= 1'b1;
      id_ff <= i_step_id;
      cnt_ff <= i_slow ? 4'h6 : 4'h0;
    end else if (busy_ff) begin
      if (cnt_ff == 4'h0) begin
        busy_ff <= 1'b0;
        o_step_done <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
  // First object result comes from the bench, other steps carry their own code
  assign o_step_value = (id_ff == ST_OBJ1) ? i_obj1 : {4'h0, id_ff, 8'ha5};
endmodule

// ==== sim/itr_top_test.sv ====
// Self-checking bench of the sequencer, output mode control and relay
`timescale 1ns/1ps
module itr_top_test;
  import itr_pkg::*;
  logic i_clk_sys, i_rst, i_sleep_exit, i_scl, i_slow, i_pwm_level, host_low;
  logic sda_out, sda_oe_n, sda_rx, bus_mode, nv_rd, nv_valid, step_go, die, done, pwm_load;
  logic [5:0] nv_addr;
  logic [15:0] nv_data, val, res_data, cfg, pctl, obj1;
  logic [3:0] step_id, res_idx;
  logic [2:0] fir, iir;
  logic [9:0] pwm_word;
  logic [6:0] slave;
  logic [3:0] ids[$];
  logic [5:0] nvs[$];
  int bad_count, checked, cyc;
  // Pin with pull-up, pulled low by the host only when released
  wire logic sda = sda_oe_n ? !host_low : sda_out;
  itr_top #(.REQ_CYCLES(20)) u_itr_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'b1),
    .i_sleep_exit(i_sleep_exit), .i_scl(i_scl), .i_sda_in(sda), .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n), .o_sda_rx(sda_rx), .o_bus_mode(bus_mode), .o_nv_addr(nv_addr),
    .o_nv_rd(nv_rd), .i_nv_data(nv_data), .i_nv_valid(nv_valid), .o_step_go(step_go),
    .o_step_id(step_id), .o_fir_len(fir), .o_iir_len(iir), .o_die_sel(die),
    .i_step_done(done), .i_step_value(val), .o_pwm_word(pwm_word), .o_pwm_load(pwm_load),
    .i_pwm_level(i_pwm_level), .o_slave_addr(slave), .i_res_idx(res_idx),
    .o_res_data(res_data));
  itr_far_model u_itr_far_model (.i_clk_sys(i_clk_sys), .i_nv_addr(nv_addr), .i_nv_rd(nv_rd),
    .i_step_go(step_go), .i_step_id(step_id), .i_cfg(cfg), .i_pctl(pctl), .i_obj1(obj1),
    .i_slow(i_slow), .o_nv_data(nv_data), .o_nv_valid(nv_valid), .o_step_done(done),
    .o_step_value(val));
  // System clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("Counts: checked=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watch loads and steps, check filter lengths, cut a hang short
  always @(posedge i_clk_sys) begin
    cyc++;
    if (nv_valid === 1'b1 && nv_rd === 1'b1) nvs.push_back(nv_addr);
    if (step_go === 1'b1) begin
      ids.push_back(step_id);
      if (step_id inside {ST_AMB_OFS, ST_IR_OFS, ST_IR_GAIN})
        chk({fir, iir}, {FIR_FIXED_LEN, IIR_FIXED_LEN});
      if (step_id inside {ST_DIE, ST_IR1, ST_IR2})
        chk({fir, iir}, {cfg[10:8], cfg[2:0]});
      if (step_id == ST_DIE) chk(die, cfg[7]);
    end
    if (cyc > 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic boot(input logic [15:0] c, input logic [15:0] p);
    cfg <= c;
    pctl <= p;
    i_rst <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    chk({sda_oe_n, sda_rx, bus_mode, step_go}, 4'hc);
    i_rst <= 1'b0;
    ids.delete();
    nvs.delete();
  endtask
  task automatic wait_go(input logic [3:0] id);
    int n;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (!(step_go === 1'b1 && step_id === id) && n < 400);
    if (n >= 400) chk(1'b0, 1'b1);
  endtask
  task automatic seq_chk(input logic dual);
    logic [5:0] ea[5] = '{CELL_MODE_CFG, 6'h20, 6'h21, CELL_PULSE_CTRL, CELL_SLAVE_ADDR};
    int n;
    n = 0;
    wait_go(ST_AMB_OFS);
    chk(16'(nvs.size()), 16'h0005);
    for (int i = 0; i < 5; i++) chk(nvs[i], ea[i]);
    wait_go(ST_AMB_OFS);
    @(posedge i_clk_sys);
    for (int i = 0; i <= 10; i++) begin
      if (dual || (i != 8 && i != 9)) begin
        chk(ids[n], i[3:0]);
        n++;
      end
    end
    chk(ids[n], ST_AMB_OFS);
  endtask
  // Walk the object result above, between, below and between the two levels
  task automatic relay(input logic od);
    logic [15:0] v[4] = '{16'h3686, 16'h3653, 16'h3621, 16'h3653};
    logic e[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int k = 0; k < 4; k++) begin
      obj1 <= v[k];
      wait_go(ST_PWM);
      repeat (3) @(posedge i_clk_sys);
      chk(res_data, v[k]);
      if (od) chk({sda_out, sda_oe_n}, {1'b0, e[k]});
      else chk({sda_out, sda_oe_n}, {e[k], 1'b0});
    end
  endtask
  initial begin
    i_rst = 1'b1;
    i_sleep_exit = 1'b0;
    i_scl = 1'b1;
    i_slow = 1'b0;
    i_pwm_level = 1'b0;
    host_low = 1'b0;
    res_idx = ST_OBJ1;
    cfg = 16'h0dca;
    pctl = 16'h0004;
    obj1 = 16'h3686;
    boot(16'h0dca, 16'h0004);
    seq_chk(1'b1);
    chk(slave, 7'h5a);
    while (pwm_load !== 1'b1 && cyc < 19000) @(posedge i_clk_sys);
    chk(pwm_word, 10'h2a5);
    relay(1'b0);
    chk(sda_rx, 1'b1);
    i_scl <= 1'b0;
    repeat (15) @(posedge i_clk_sys);
    i_scl <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    chk(bus_mode, 1'b0);
    i_scl <= 1'b0;
    repeat (30) @(posedge i_clk_sys);
    chk({bus_mode, sda_oe_n}, 2'h3);
    // Bus frame on the link clock, host pulls the data line low
    host_low <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      repeat (8) @(posedge i_clk_sys);
      i_scl <= ~i_scl;
      repeat (8) @(posedge i_clk_sys);
      i_scl <= ~i_scl;
    end
    chk(sda_rx, 1'b0);
    host_low <= 1'b0;
    i_scl <= 1'b1;
    wait_go(ST_OBJ1);
    chk(bus_mode, 1'b1);
    i_sleep_exit <= 1'b1;
    @(posedge i_clk_sys);
    i_sleep_exit <= 1'b0;
    wait_go(ST_PWM);
    repeat (3) @(posedge i_clk_sys);
    chk({bus_mode, sda_oe_n}, 2'h0);
    $display("test relay_push_pull done");
    i_slow <= 1'b1;
    boot(16'h0d8a, 16'h0000);
    seq_chk(1'b0);
    relay(1'b1);
    $display("test relay_open_drain done");
    i_slow <= 1'b0;
    boot(16'h0d82, 16'h0004);
    wait_go(ST_AMB_OFS);
    chk(bus_mode, 1'b0);
    for (int k = 0; k < 2; k++) begin
      i_pwm_level <= !k[0];
      repeat (4) @(posedge i_clk_sys);
      chk({sda_out, sda_oe_n}, {!k[0], 1'b0});
    end
    $display("test pulse_output done");
    boot(16'h05ca, 16'h0004);
    wait_go(ST_AMB_OFS);
    chk({bus_mode, sda_oe_n}, 2'h3);
    $display("test bus_default done");
    test_done();
  end
endmodule
